// >>> verilog/scfs_pkg.sv
// Purpose: Shared constants and carriers for the serial control framer
// Assumes: Frame bit 0 is the first bit on the line
// Notes:   Preamble fields sit in the low 16 bits of a frame

package scfs_pkg;

  // Frame geometry
  localparam int FRAME_BITS = 48;
  localparam int PRE_BITS   = 16;
  localparam int DATA_BITS  = 32;
  localparam int NUM_WORDS  = 16;
  localparam int IDX_W      = 4;
  localparam int CNT_W      = 6;

  // Last bit index of a frame, at counter width
  localparam logic [CNT_W-1:0] LAST_BIT = 6'h2f;

  // Fixed preamble contents, bit 0 in the lsb
  localparam logic [5:0] SYNC_PAT      = 6'h3e;
  localparam logic [1:0] TR_CODE_TX    = 2'h1;
  localparam logic [1:0] TR_CODE_RX    = 2'h2;
  localparam logic [1:0] TR_CODE_BAD   = 2'h3;
  localparam logic       RET_MON_OFF   = 1'h0;
  localparam logic [1:0] ADDR_SEC_NONE = 2'h0;

  // Word roles
  localparam logic [IDX_W-1:0] MONITOR_WORD = 4'h0;
  localparam logic [IDX_W-1:0] ROUTINE_INIT = 4'hf;
  localparam logic [15:0]      GEN_MASK_DEF = 16'h000b;
  localparam logic [15:0]      RECALL_MASK_DEF = 16'h00fe;
  localparam logic [15:0]      NO_RECALL_MASK  = 16'hff00;

  // Bit at which the link asks for its next frame
  localparam int REQ_BIT_DEF = 40;

  // Preamble, listed msb first
  typedef struct packed {
    logic [IDX_W-1:0] ident;
    logic [1:0]       addrSec;
    logic             retMon;
    logic             inhibit;
    logic [1:0]       trCode;
    logic [5:0]       sync;
  } scfs_pre_t;

  // Whole frame, data above the preamble
  typedef struct packed {
    logic [DATA_BITS-1:0] data;
    scfs_pre_t            pre;
  } scfs_frame_t;

  // Result of one revertive frame
  typedef struct packed {
    logic [IDX_W-1:0]     wordNum;
    logic [DATA_BITS-1:0] data;
    logic                 inhibitSeen;
    logic                 repeated;
    logic                 checkOk;
  } scfs_rev_t;

  // Link side states
  typedef enum logic [1:0] {
    LK_WAIT  = 2'b01,
    LK_SHIFT = 2'b10
  } scfs_link_t;

endpackage : scfs_pkg

// >>> verilog/scfs_sync.sv
// Purpose: Two-stage synchroniser for levels and toggles
// Assumes: Each bit is independent; no bus coherence across bits
// Notes:   First stage feeds only the second stage

`timescale 1ns/100ps

module scfs_sync #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // No reset: value settles within two edges anyway
  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule : scfs_sync

// >>> verilog/scfs_frame_sender.sv
// Purpose: Forward serial control framer with revertive frame capture
// Assumes: linkClk is free running; line clock is half its rate
// Notes:   Word choice lives on clk, bit shifting on linkClk
//
// Notes on behaviour
// RQ1 - Frame is 16 preamble then 32 data bits
// RQ2 - Sixteen word numbers, one per frame type
// RQ3 - Far end can return any word revertively
// RQ4 - Separate data and clock lines each way
// RQ5 - Only words 0, 1 and 3 are generated
// RQ6 - Word 0 sent, but carries no control data
// RQ7 - Words 1 to 7 recallable; 8 to 15 not
// RQ8 - Words 2,4,5,8,9 reserved; rest for extension
// RQ9 - No change: ascending words back to back
// RQ10 - Changed word goes in the very next frame
// RQ11 - One pending latch per word, set on change
// RQ12 - Latch clears when its word is sent
// RQ13 - Receiver acts only on two identical frames
// RQ14 - Bits 0 to 5 are zero then five ones
// RQ15 - Bits 6,7 code transmit or receive, never both
// RQ16 - Bit 8 set makes receiver ignore control
// RQ17 - Bits 12 to 15 hold binary word number
// RQ18 - Lowest pending word first, then routine resumes
// RQ19 - Change during sending keeps the latch set

`timescale 1ns/100ps

module scfs_frame_sender #(
  parameter logic [15:0] GEN_MASK    = scfs_pkg::GEN_MASK_DEF,
  parameter logic [15:0] RECALL_MASK = scfs_pkg::RECALL_MASK_DEF,
  parameter int          REQ_BIT     = scfs_pkg::REQ_BIT_DEF
) (
  // Clocks and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   linkClk,
  // Settings side
  input  wire logic [15:0][31:0]      liveWords,
  input  wire logic                   txState,
  input  wire logic                   ctrlInhibit,
  input  wire logic                   storeStrobe,
  input  wire logic                   recallStrobe,
  // Forward link
  output logic                        ctrlDataOut,
  output logic                        ctrlClkOut,
  // Revertive link
  input  wire logic                   revClkIn,
  input  wire logic                   revDataIn,
  // Status
  output logic [15:0]                 pendingWords,
  output logic                        revValid,
  output scfs_pkg::scfs_rev_t         revResult
);

  localparam int NW = scfs_pkg::NUM_WORDS;
  localparam int FB = scfs_pkg::FRAME_BITS;

  // Refuse settings the logic cannot serve
  if (REQ_BIT < 1 || REQ_BIT > FB - 3) begin : g_bad_req
    $error("REQ_BIT out of range");
  end
  if ((GEN_MASK & scfs_pkg::GEN_MASK_DEF) != GEN_MASK) begin : g_bad_gen
    $error("GEN_MASK may only select words 0, 1 and 3");
  end
  if ((RECALL_MASK & scfs_pkg::NO_RECALL_MASK) != 16'h0000) begin : g_bad_rec
    $error("RECALL_MASK may not hold words 8 to 15");
  end

  // ---------------- clk domain: settings and word choice -------------

  logic [31:0]                 actWord_r  [NW];
  logic [31:0]                 store_r    [NW];
  logic [31:0]                 livePrev_r [NW];
  wire  logic [NW-1:0]         setMask;
  logic [NW-1:0]               clrMask;
  logic [NW-1:0]               pending_r;
  logic [scfs_pkg::IDX_W-1:0]  routineIdx_r;
  logic [scfs_pkg::IDX_W-1:0]  pickIdx;
  logic [scfs_pkg::IDX_W-1:0]  routineNxt;
  logic [scfs_pkg::IDX_W-1:0]  cand;
  logic                        anyPend;
  logic                        routineFound;
  scfs_pkg::scfs_frame_t       frameHold_r;
  scfs_pkg::scfs_frame_t       frameNxt;
  logic                        ackTgl_r;
  logic                        reqSync;
  logic                        reqSeen_r;
  logic                        reqEdge;
  logic                        reqTgl_r;

  // Per word: active value, recall store and change latch set
  for (genvar w = 0; w < NW; w++) begin : g_word
    if (GEN_MASK[w] && w != int'(scfs_pkg::MONITOR_WORD)) begin : g_gen // RQ5
      logic [31:0] actNxt;
      logic        liveChange;
      assign liveChange = liveWords[w] != livePrev_r[w];
      // Recall wins; it stands until the live setting moves again
      always_comb begin
        actNxt = actWord_r[w];
        if (recallStrobe && RECALL_MASK[w]) begin // RQ7
          actNxt = store_r[w];
        end else if (liveChange) begin
          actNxt = liveWords[w];
        end
      end
      assign setMask[w] = actNxt != actWord_r[w]; // RQ11
      always_ff @(posedge clk) begin
        if (rst) begin
          actWord_r[w]  <= 32'h0000_0000;
          livePrev_r[w] <= 32'h0000_0000;
        end else begin
          actWord_r[w]  <= actNxt;
          livePrev_r[w] <= liveWords[w];
        end
      end
      if (RECALL_MASK[w]) begin : g_rec
        // Recall store, only words 1 to 7 may have one
        always_ff @(posedge clk) begin
          if (rst) begin
            store_r[w] <= 32'h0000_0000;
          end else if (storeStrobe) begin
            store_r[w] <= actWord_r[w]; // RQ7
          end
        end
      end else begin : g_norec
        assign store_r[w] = 32'h0000_0000;
      end
    end else begin : g_none
      // Monitor word and every word not generated carry no control data
      assign actWord_r[w]  = 32'h0000_0000; // RQ6 RQ8
      assign store_r[w]    = 32'h0000_0000;
      assign livePrev_r[w] = 32'h0000_0000;
      assign setMask[w]    = 1'b0;
    end
  end

  // Request from the link, toggle crossing
  scfs_sync #(.W(1)) u_reqSync (
    .clk (clk),
    .d   (reqTgl_r),
    .q   (reqSync)
  );
  assign reqEdge = reqSync ^ reqSeen_r;

  // Word choice: lowest pending, else next routine word
  always_comb begin
    anyPend      = |pending_r;
    pickIdx      = routineIdx_r;
    routineNxt   = routineIdx_r;
    routineFound = 1'b0;
    cand         = routineIdx_r;
    for (int i = NW - 1; i >= 0; i--) begin
      if (pending_r[i]) begin
        pickIdx = scfs_pkg::IDX_W'(i); // RQ18 RQ10
      end
    end
    for (int k = 1; k <= NW; k++) begin
      cand = routineIdx_r + scfs_pkg::IDX_W'(k);
      if (!routineFound && GEN_MASK[cand]) begin
        routineNxt   = cand; // RQ9
        routineFound = 1'b1;
      end
    end
    if (!anyPend) begin
      pickIdx = routineNxt;
    end
  end

  // Frame assembly for the chosen word
  always_comb begin
    frameNxt.pre.sync    = scfs_pkg::SYNC_PAT; // RQ14
    frameNxt.pre.trCode  = txState ? scfs_pkg::TR_CODE_TX
                                   : scfs_pkg::TR_CODE_RX; // RQ15
    frameNxt.pre.inhibit = ctrlInhibit; // RQ16
    frameNxt.pre.retMon  = scfs_pkg::RET_MON_OFF;
    frameNxt.pre.addrSec = scfs_pkg::ADDR_SEC_NONE;
    frameNxt.pre.ident   = pickIdx; // RQ17
    frameNxt.data        = actWord_r[pickIdx]; // RQ1 RQ2
    clrMask              = '0;
    if (reqEdge && anyPend) begin
      clrMask[pickIdx] = 1'b1; // RQ12
    end
  end

  // Pending latches; a fresh change beats the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_r <= '0;
    end else begin
      pending_r <= (pending_r & ~clrMask) | setMask; // RQ19
    end
  end

  // Snapshot on request, then hand over by toggle
  always_ff @(posedge clk) begin
    if (rst) begin
      frameHold_r  <= '0;
      ackTgl_r     <= 1'b0;
      reqSeen_r    <= 1'b0;
      routineIdx_r <= scfs_pkg::ROUTINE_INIT;
    end else begin
      reqSeen_r <= reqSync;
      if (reqEdge) begin
        frameHold_r <= frameNxt;
        ackTgl_r    <= ~ackTgl_r;
        if (!anyPend) begin
          routineIdx_r <= routineNxt; // RQ18
        end
      end
    end
  end

  // Status registered one clk behind the latches
  always_ff @(posedge clk) begin
    if (rst) begin
      pendingWords <= '0;
    end else begin
      pendingWords <= pending_r;
    end
  end

  // ---------------- linkClk domain: bit shifting ----------------------

  logic                        rstLink;
  logic                        ackSync;
  logic                        ackSeen_r;
  logic                        primed_r;
  logic                        haveNext_r;
  logic [FB-1:0]               nextFrame_r;
  logic [FB-1:0]               shift_r;
  logic [scfs_pkg::CNT_W-1:0]  bitCnt_r;
  scfs_pkg::scfs_link_t        lkState_r;
  logic                        ackEdge;
  logic                        loadNow;

  localparam logic [scfs_pkg::CNT_W-1:0] REQ_AT =
    scfs_pkg::CNT_W'(REQ_BIT);

  // Reset level and acknowledge cross into the link domain
  scfs_sync #(.W(2)) u_lnkSync (
    .clk (linkClk),
    .d   ({rst, ackTgl_r}),
    .q   ({rstLink, ackSync})
  );
  assign ackEdge = ackSync ^ ackSeen_r;

  // Frame boundary: load when the last bit finishes or when waiting
  assign loadNow = haveNext_r &&
                   ((lkState_r == scfs_pkg::LK_WAIT) ||
                    (ctrlClkOut && bitCnt_r == scfs_pkg::LAST_BIT));

  // Next-frame buffer filled from the clk side snapshot
  always_ff @(posedge linkClk) begin
    if (rstLink) begin
      ackSeen_r   <= 1'b0;
      haveNext_r  <= 1'b0;
      nextFrame_r <= '0;
    end else begin
      ackSeen_r <= ackSync;
      if (ackEdge) begin
        nextFrame_r <= frameHold_r; // Stable until the next request
        haveNext_r  <= 1'b1;
      end else if (loadNow) begin
        haveNext_r <= 1'b0;
      end
    end
  end

  // Late request so a change just before the boundary still goes next
  always_ff @(posedge linkClk) begin
    if (rstLink) begin
      reqTgl_r <= 1'b0;
      primed_r <= 1'b0;
    end else if (!primed_r) begin
      reqTgl_r <= ~reqTgl_r;
      primed_r <= 1'b1;
    end else if (lkState_r == scfs_pkg::LK_SHIFT && ctrlClkOut &&
                 bitCnt_r == REQ_AT) begin
      reqTgl_r <= ~reqTgl_r; // RQ10
    end
  end

  // Shifter: data moves while line clock falls, held while high
  always_ff @(posedge linkClk) begin
    if (rstLink) begin
      lkState_r   <= scfs_pkg::LK_WAIT;
      shift_r     <= '0;
      bitCnt_r    <= '0;
      ctrlClkOut  <= 1'b0;
      ctrlDataOut <= 1'b0;
    end else begin
      case (lkState_r)
        scfs_pkg::LK_WAIT: begin
          ctrlClkOut <= 1'b0;
          if (loadNow) begin
            shift_r     <= nextFrame_r;
            ctrlDataOut <= nextFrame_r[0]; // RQ1
            bitCnt_r    <= '0;
            lkState_r   <= scfs_pkg::LK_SHIFT;
          end
        end
        scfs_pkg::LK_SHIFT: begin
          ctrlClkOut <= ~ctrlClkOut; // RQ4
          if (ctrlClkOut) begin
            if (bitCnt_r != scfs_pkg::LAST_BIT) begin
              bitCnt_r    <= bitCnt_r + 1'b1;
              ctrlDataOut <= shift_r[1];
              shift_r     <= {1'b0, shift_r[FB-1:1]};
            end else if (loadNow) begin
              shift_r     <= nextFrame_r; // RQ9 back to back
              ctrlDataOut <= nextFrame_r[0];
              bitCnt_r    <= '0;
            end else begin
              ctrlDataOut <= 1'b0;
              lkState_r   <= scfs_pkg::LK_WAIT;
            end
          end
        end
        default: begin
          lkState_r <= scfs_pkg::LK_WAIT;
        end
      endcase
    end
  end

  // ---------------- clk domain: revertive capture ---------------------

  logic                        revClkS;
  logic                        revDatS;
  logic                        revClkPrev_r;
  logic [FB-1:0]               revShift_r;
  logic [FB-1:0]               revLast_r;
  logic [FB-1:0]               revNxt;
  logic [scfs_pkg::CNT_W-1:0]  revCnt_r;
  logic                        revHit;
  scfs_pkg::scfs_frame_t       revFrm;

  // Revertive pins reach logic only after two flops
  scfs_sync #(.W(2)) u_revSync (
    .clk (clk),
    .d   ({revClkIn, revDataIn}),
    .q   ({revClkS, revDatS})
  );

  // Five ones are unique, so the sync window marks alignment
  always_comb begin
    revNxt = {revDatS, revShift_r[FB-1:1]};
    revFrm = revNxt;
    revHit = (revClkS && !revClkPrev_r) &&
             revCnt_r >= scfs_pkg::LAST_BIT &&
             revFrm.pre.sync == scfs_pkg::SYNC_PAT && // RQ14
             revFrm.pre.trCode != scfs_pkg::TR_CODE_BAD; // RQ15
  end

  // Shift on rising revertive clock, report each whole frame not coded TR_CODE_BAD
  always_ff @(posedge clk) begin
    if (rst) begin
      revClkPrev_r <= 1'b0;
      revShift_r   <= '0;
      revLast_r    <= '0;
      revCnt_r     <= '0;
      revValid     <= 1'b0;
      revResult    <= '0;
    end else begin
      revClkPrev_r <= revClkS;
      revValid     <= revHit; // RQ3
      if (revClkS && !revClkPrev_r) begin
        revShift_r <= revNxt;
        if (revHit) begin
          revCnt_r <= '0;
        end else if (revCnt_r != scfs_pkg::LAST_BIT) begin
          revCnt_r <= revCnt_r + 1'b1;
        end
      end
      if (revHit) begin
        revLast_r             <= revNxt;
        revResult.wordNum     <= revFrm.pre.ident;
        revResult.data        <= revFrm.data;
        revResult.inhibitSeen <= revFrm.pre.inhibit;
        revResult.repeated    <= revNxt == revLast_r; // RQ13
        revResult.checkOk     <= revFrm.data == actWord_r[revFrm.pre.ident];
      end
    end
  end

endmodule : scfs_frame_sender

// >>> dv/scfs_frame_sender_assertions.sv
// Purpose: Port checker for the serial control framer
// Assumes: Line clock idles low, so the first pulse is bit 0
// Notes:   Forward frames are rebuilt from the line pins
`timescale 1ns/100ps
module scfs_chk #(
  parameter logic [15:0] GEN_MASK    = scfs_pkg::GEN_MASK_DEF,
  parameter logic [15:0] RECALL_MASK = scfs_pkg::RECALL_MASK_DEF,
  parameter int          REQ_BIT     = scfs_pkg::REQ_BIT_DEF
) (
  // Clocks and reset
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                linkClk,
  // Settings side
  input wire logic [15:0][31:0]   liveWords,
  input wire logic                txState,
  input wire logic                ctrlInhibit,
  input wire logic                storeStrobe,
  input wire logic                recallStrobe,
  // Line pins
  input wire logic                ctrlDataOut,
  input wire logic                ctrlClkOut,
  input wire logic                revClkIn,
  input wire logic                revDataIn,
  // Status
  input wire logic [15:0]         pendingWords,
  input wire logic                revValid,
  input wire scfs_pkg::scfs_rev_t revResult
);
  logic [47:0] frm_r;
  logic [5:0]  bitCnt_r;
  logic        frmDone_r;

  // Frames are back to back, so a plain count keeps alignment
  always_ff @(posedge linkClk) begin
    if (rst) begin
      bitCnt_r  <= 6'h00;
      frmDone_r <= 1'b0;
    end else begin
      frmDone_r <= ctrlClkOut && (bitCnt_r == scfs_pkg::LAST_BIT);
      if (ctrlClkOut) begin
        frm_r    <= {ctrlDataOut, frm_r[47:1]};
        bitCnt_r <= (bitCnt_r == scfs_pkg::LAST_BIT) ? 6'h00
                                                     : bitCnt_r + 6'h01;
      end
    end
  end

  AST_SYNC: assert property (@(posedge linkClk) disable iff (rst)
    frmDone_r |-> frm_r[5:0] == scfs_pkg::SYNC_PAT)
    else $error("sync field wrong");
  AST_TRCODE: assert property (@(posedge linkClk) disable iff (rst)
    frmDone_r |-> frm_r[7:6] != scfs_pkg::TR_CODE_BAD && frm_r[7:6] != 2'h0)
    else $error("transmit receive code wrong");
  AST_WORD: assert property (@(posedge linkClk) disable iff (rst)
    frmDone_r |-> GEN_MASK[frm_r[15:12]])
    else $error("word number not generated");
  AST_MONZERO: assert property (@(posedge linkClk) disable iff (rst)
    frmDone_r && frm_r[15:12] == 4'h0 |-> frm_r[47:16] == 32'h0)
    else $error("monitor word carries data");
  AST_ADDR: assert property (@(posedge linkClk) disable iff (rst)
    frmDone_r |-> frm_r[11:9] == 3'h0)
    else $error("address bits set");
  AST_HALFRATE: assert property (@(posedge linkClk) disable iff (rst)
    ctrlClkOut |=> !ctrlClkOut ##1 ctrlClkOut)
    else $error("line clock broken in frame");
  AST_STABLE: assert property (@(posedge linkClk) disable iff (rst)
    $rose(ctrlClkOut) |-> $stable(ctrlDataOut))
    else $error("data moved on rising line clock");
  AST_PENDMASK: assert property (@(posedge clk) disable iff (rst)
    (pendingWords & ~GEN_MASK) == 16'h0000)
    else $error("latch set for unused word");
  AST_PENDSET: assert property (@(posedge clk) disable iff (rst)
    $changed(liveWords[1]) |-> ##[1:3] pendingWords[1])
    else $error("latch not set after change");
  AST_REVPULSE: assert property (@(posedge clk) disable iff (rst)
    revValid |=> !revValid)
    else $error("revertive valid too long");

  // Main scenarios reached
  COV_W1: cover property (@(posedge linkClk)
    frmDone_r && frm_r[15:12] == 4'h1);
  COV_INH: cover property (@(posedge linkClk) frmDone_r && frm_r[8]);
  COV_TWO: cover property (@(posedge clk) pendingWords == 16'h000a);
  COV_REP: cover property (@(posedge clk) revValid && revResult.repeated);
endmodule : scfs_chk

bind scfs_frame_sender scfs_chk #(
  .GEN_MASK(GEN_MASK), .RECALL_MASK(RECALL_MASK), .REQ_BIT(REQ_BIT)
) i_chk (
  .clk(clk), .rst(rst), .linkClk(linkClk), .liveWords(liveWords),
  .txState(txState), .ctrlInhibit(ctrlInhibit),
  .storeStrobe(storeStrobe), .recallStrobe(recallStrobe),
  .ctrlDataOut(ctrlDataOut), .ctrlClkOut(ctrlClkOut),
  .revClkIn(revClkIn), .revDataIn(revDataIn),
  .pendingWords(pendingWords), .revValid(revValid), .revResult(revResult)
);

// >>> dv/scfs_remote_model.sv
// Purpose: Remote receiver with a revertive sender
// Assumes: Forward line idles low between runs of frames
// Notes:   Revertive clock runs only within a frame
`timescale 1ns/100ps
module scfs_remote_model (
  // Forward line
  input  wire logic        ctrlDataOut,
  input  wire logic        ctrlClkOut,
  // Revertive line
  output logic             revClkIn,
  output logic             revDataIn,
  // Bench side
  input  wire logic        sendGo,
  input  wire logic [47:0] sendFrame,
  output logic [47:0]      rxFrame,
  output int               rxCount,
  output int               execCount
);
  logic [47:0] sr;
  logic [47:0] prevFrm;
  int          bits;

  initial begin
    revClkIn = 1'b0;
    revDataIn = 1'b1;
    bits = 0;
    rxCount = 0;
    execCount = 0;
    prevFrm = '0;
  end

  // Sample on rising line clock, bit 0 first
  always @(posedge ctrlClkOut) begin
    sr = {ctrlDataOut, sr[47:1]};
    bits = bits + 1;
    if (bits == 48) begin
      bits = 0;
      rxFrame = sr;
      rxCount = rxCount + 1;
      // Act only on a repeat, never with control inhibited
      if (sr == prevFrm && !sr[8]) execCount = execCount + 1;
      prevFrm = sr;
    end
  end

  // Half period above three system clocks; line inverts once released
  always @(posedge sendGo) begin
    for (int i = 0; i < 48; i++) begin
      revDataIn = sendFrame[i];
      #14 revClkIn = 1'b1;
      #14 revClkIn = 1'b0;
    end
    revDataIn = ~revDataIn;
  end
endmodule : scfs_remote_model

// >>> dv/scfs_frame_sender_tb_top.sv
// Purpose: Self-checking bench for the serial control framer
// Assumes: Default request bit; words 1 and 3 carry settings
// Notes:   Frames are judged against values built here, whole or by word number
`timescale 1ns/100ps
module scfs_frame_sender_tb_top;
  logic clk, rst, linkClk, txState, ctrlInhibit, storeStrobe, recallStrobe;
  logic ctrlDataOut, ctrlClkOut, revClkIn, revDataIn, revValid, sendGo;
  logic [15:0][31:0]   liveWords;
  logic [15:0]         pendingWords;
  logic [47:0]         sendFrame, rxFrame, fr;
  scfs_pkg::scfs_rev_t revResult;
  int                  rxCount, fails, testsRun;

  scfs_frame_sender i_dut (.clk(clk), .rst(rst), .linkClk(linkClk),
    .liveWords(liveWords), .txState(txState), .ctrlInhibit(ctrlInhibit),
    .storeStrobe(storeStrobe), .recallStrobe(recallStrobe),
    .ctrlDataOut(ctrlDataOut), .ctrlClkOut(ctrlClkOut), .revClkIn(revClkIn),
    .revDataIn(revDataIn), .pendingWords(pendingWords),
    .revValid(revValid), .revResult(revResult));
  scfs_remote_model i_far (.ctrlDataOut(ctrlDataOut),
    .ctrlClkOut(ctrlClkOut), .revClkIn(revClkIn), .revDataIn(revDataIn),
    .sendGo(sendGo), .sendFrame(sendFrame), .rxFrame(rxFrame),
    .rxCount(rxCount), .execCount());

  // Clocks unrelated in phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #3.3;
    forever #6 linkClk = ~linkClk;
  end

  task automatic printVerdict();
    $display("Comparisons %0d, mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : printVerdict

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Expected frame from the current settings
  function automatic logic [47:0] mk(input logic [3:0] w,
                                     input logic [31:0] d);
    scfs_pkg::scfs_frame_t f;
    f.data = d;
    f.pre.ident = w;
    f.pre.addrSec = scfs_pkg::ADDR_SEC_NONE;
    f.pre.retMon = scfs_pkg::RET_MON_OFF;
    f.pre.inhibit = ctrlInhibit;
    f.pre.trCode = txState ? scfs_pkg::TR_CODE_TX : scfs_pkg::TR_CODE_RX;
    f.pre.sync = scfs_pkg::SYNC_PAT;
    return f;
  endfunction : mk

  function automatic logic [31:0] dataOf(input logic [3:0] w);
    return (w == 4'h0) ? 32'h0 : liveWords[w];
  endfunction : dataOf

  task automatic getFrame(output logic [47:0] f);
    int c0;
    c0 = rxCount;
    for (int i = 0; i < 1000 && rxCount == c0; i++) @(negedge clk);
    chk(rxCount != c0, 1'b1);
    if (rxCount == c0) printVerdict();
    f = rxFrame;
  endtask : getFrame

  task automatic expectNext(input logic [3:0] w, input logic [31:0] d);
    getFrame(fr);
    chk(fr, mk(w, d));
  endtask : expectNext

  // Skip to a frame of word w, or to a whole expected frame
  task automatic seek(input logic [3:0] w, input logic [47:0] e,
                      input bit whole);
    for (int i = 0; i < 6; i++) begin
      getFrame(fr);
      if (whole ? fr === e : fr[15:12] === w) break;
    end
    chk(whole ? fr : fr[15:12], whole ? e : w);
  endtask : seek

  task automatic setWord(input int w, input logic [31:0] d);
    @(negedge clk);
    liveWords[w] = d;
  endtask : setWord

  task automatic tRoutine();
    seek(4'h0, '0, 0);
    for (int i = 0; i < 6; i++) begin
      expectNext((i % 3 == 0) ? 4'h1 : (i % 3 == 1) ? 4'h3 : 4'h0,
                 dataOf((i % 3 == 0) ? 4'h1 : (i % 3 == 1) ? 4'h3 : 4'h0));
    end
  endtask : tRoutine

  task automatic tModes();
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      txState = m[0];
      ctrlInhibit = m[1];
      getFrame(fr);
      getFrame(fr);
      getFrame(fr);
      chk(fr, mk(fr[15:12], dataOf(fr[15:12])));
    end
    txState = 1'b1;
    ctrlInhibit = 1'b0;
  endtask : tModes

  // Word 1 changed while word 3 is in flight jumps ahead of word 0
  task automatic tUpdate();
    seek(4'h1, '0, 0);
    setWord(1, 32'h0f0f_1111);
    repeat (4) @(negedge clk);
    chk(pendingWords[1], 1'b1);
    expectNext(4'h3, dataOf(4'h3));
    expectNext(4'h1, 32'h0f0f_1111);
    chk(pendingWords[1], 1'b0);
    expectNext(4'h0, 32'h0);
  endtask : tUpdate

  // Several latches, lowest first; unused words never latch
  task automatic tMulti();
    seek(4'h3, '0, 0);
    @(negedge clk);
    liveWords[3] = 32'h0303_0303;
    liveWords[1] = 32'h0101_0101;
    liveWords[2] = 32'h0202_0202;
    liveWords[8] = 32'h0808_0808;
    repeat (4) @(negedge clk);
    chk(pendingWords, 16'h000a);
    expectNext(4'h0, 32'h0);
    expectNext(4'h1, 32'h0101_0101);
    expectNext(4'h3, 32'h0303_0303);
    expectNext(4'h1, 32'h0101_0101);
  endtask : tMulti

  // A change after the snapshot sends the word once more
  task automatic tResend();
    int n;
    seek(4'h0, '0, 0);
    setWord(1, 32'h1111_2222);
    for (n = 0; n < 800 && pendingWords[1] !== 1'b1; n++) @(negedge clk);
    chk(pendingWords[1], 1'b1);
    for (n = 0; n < 800 && pendingWords[1] !== 1'b0; n++) @(negedge clk);
    chk(pendingWords[1], 1'b0);
    setWord(1, 32'h3333_4444);
    expectNext(4'h1, 32'h0101_0101);
    expectNext(4'h1, 32'h1111_2222);
    expectNext(4'h1, 32'h3333_4444);
    expectNext(4'h3, dataOf(4'h3));
  endtask : tResend

  task automatic tRecall();
    @(negedge clk);
    storeStrobe = 1'b1;
    @(negedge clk);
    storeStrobe = 1'b0;
    setWord(1, 32'h5555_aaaa);
    seek(4'h1, mk(4'h1, 32'h5555_aaaa), 1);
    @(negedge clk);
    recallStrobe = 1'b1;
    @(negedge clk);
    recallStrobe = 1'b0;
    seek(4'h1, mk(4'h1, 32'h3333_4444), 1);
  endtask : tRecall

  // One revertive frame; wait for acceptance
  task automatic sendRev(input logic [47:0] f, input logic [38:0] exp,
                         input bit take);
    bit seen;
    seen = 0;
    repeat (12) @(negedge clk);
    sendFrame = f;
    sendGo = 1'b1;
    @(negedge clk);
    sendGo = 1'b0;
    for (int i = 0; i < 450 && !seen; i++) begin
      @(negedge clk);
      if (revValid === 1'b1) begin
        seen = 1;
        chk(revResult, exp);
      end
    end
    chk(seen, take);
  endtask : sendRev

  task automatic tRev();
    logic [47:0] f;
    f = mk(4'h3, liveWords[3]);
    sendRev(f, {4'h3, liveWords[3], 3'b001}, 1);
    sendRev(f, {4'h3, liveWords[3], 3'b011}, 1);
    f = mk(4'h0, 32'h5);
    f[8] = 1'b1;
    sendRev(f, {4'h0, 32'h5, 3'b100}, 1);
    f[7:6] = scfs_pkg::TR_CODE_BAD;
    sendRev(f, '0, 0);
  endtask : tRev

  initial begin
    rst = 1'b1;
    txState = 1'b1;
    ctrlInhibit = 1'b0;
    storeStrobe = 1'b0;
    recallStrobe = 1'b0;
    sendGo = 1'b0;
    sendFrame = '0;
    fails = 0;
    testsRun = 0;
    for (int w = 0; w < 16; w++) liveWords[w] = 32'h1234_5670 + w;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    tRoutine();
    tModes();
    tUpdate();
    tMulti();
    tResend();
    tRecall();
    tRev();
    printVerdict();
  end
endmodule : scfs_frame_sender_tb_top
